// >>> common/prci_regs.vh
// Constants for the pump remote contact interface: offsets, fields, timing.
`ifndef PRCI_REGS_VH
`define PRCI_REGS_VH

// Register byte offsets on the APB slave.
`define PRCI_OFF_CFG        8'h00
`define PRCI_OFF_STATUS     8'h04
`define PRCI_OFF_EVCNT      8'h08

// Configuration register fields.
`define PRCI_CFG_ALARM_ALT  0
`define PRCI_CFG_REMOTE_ALT 1
`define PRCI_CFG_HALT_SER   2
`define PRCI_CFG_WARN_ALT   3
`define PRCI_CFG_W          4
`define PRCI_CFG_RST        4'h0

// Status register fields.
`define PRCI_ST_START       0
`define PRCI_ST_HALT        1
`define PRCI_ST_RESET       2
`define PRCI_ST_LOWSPD      3
`define PRCI_ST_READY       4
`define PRCI_ST_REMOTE      5
`define PRCI_ST_RELAY_LSB   6
`define PRCI_ST_RELAY_W     7

// Timing: clock rate, power-up hold-off and contact debounce time.
`define PRCI_CLK_MHZ        250
`define PRCI_CLK_KHZ        250000
`define PRCI_PWRUP_MS       6000
// The counts are the two times above in clock cycles, sized to their ports.
`define PRCI_PWRUP_CYC      31'h5968_2F00
`define PRCI_DEB_US         5000
`define PRCI_DEB_CYC        21'h13_12D0

`endif

// >>> hw/prci_debounce.v
// Two-flop synchroniser and stability filter for one contact input.
`timescale 1ns/1ps
module prci_debounce #(
    parameter        CW        = 21,
    parameter [20:0] DEB_CYC   = 21'h13_12D0,
    parameter        IDLE_LVL  = 1'b1
) (
    input  wire      clock,
    input  wire      rst_n,
    input  wire      raw,
    output reg       clean_q
);
    reg          sync1_q;
    reg          sync2_q;
    reg [CW-1:0] cnt_q;
    reg [CW-1:0] cnt_d;

    // Only the second stage looks at the first one.
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_q <= IDLE_LVL;
            sync2_q <= IDLE_LVL;
        end
        else
        begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
        end
    end

    always @*
    begin
        cnt_d = {CW{1'b0}};
        if (sync2_q != clean_q)
            cnt_d = cnt_q + {{(CW-1){1'b0}}, 1'b1};
    end

    // The level changes only after it has held for the whole window, so
    // bounce on one closure cannot make more than one edge.
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q   <= {CW{1'b0}};
            clean_q <= IDLE_LVL;
        end
        else if ((sync2_q != clean_q) && (cnt_q >= DEB_CYC - 21'h00_0001))
        begin
            cnt_q   <= {CW{1'b0}};
            clean_q <= sync2_q;
        end
        else
        begin
            cnt_q   <= cnt_d;
        end
    end
endmodule

// >>> hw/prci_top.v
// Remote contact interface of the pump supply, with an APB register slave.
//
// Operation
// - Start input shorted while remote operation allowed starts the pump.
// - Halt input opened stops the pump; held shorted it permits running.
// - Open halt beats a shorted start; no start then.
// - Reset input shorted requests an error reset.
// - Exactly one reset event for each closure of the reset contact.
// - Reduced-rate input shorted selects reduced speed running.
// - Spinning relay pair follows rotor rotation.
// - Rated-speed relay pair follows normal rated rotation.
// - Spin-up relay pair follows acceleration.
// - Slowing relay pair follows deceleration.
// - Remote-permitted relay pair follows remote availability.
// - Fault relay pair follows alarm presence in default setting.
// - Caution relay pair follows warning presence in default setting.
// - About six seconds after power-on before any status relay turns on.
// - Start, reset and reduced-rate contacts act only with the selector set to remote.
// - Halt, remote, fault and caution behaviour chosen by configuration.
// - Legacy remote mode drops remote relay during regenerative braking.
// - Halt honoured when remote available, or also on serial link.
`timescale 1ns/1ps
`include "prci_regs.vh"
module prci_top #(
    parameter [30:0] PWRUP_CYC = `PRCI_PWRUP_CYC,
    parameter [20:0] DEB_CYC   = `PRCI_DEB_CYC
) (
    input  wire        clock,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        start_n,
    input  wire        halt_n,
    input  wire        reset_n,
    input  wire        low_speed_n,
    input  wire        remote_sel,
    input  wire        serial_mode,
    input  wire        rotating,
    input  wire        rated_speed,
    input  wire        accelerating,
    input  wire        decelerating,
    input  wire        regen_braking,
    input  wire        alarm,
    input  wire        warning,
    output reg         start_cmd_q,
    output reg         stop_cmd_q,
    output reg         reset_cmd_q,
    output reg         run_allow_q,
    output reg         low_speed_q,
    output reg         spin_make_q,
    output reg         spin_break_q,
    output reg         rated_make_q,
    output reg         rated_break_q,
    output reg         spinup_make_q,
    output reg         spinup_break_q,
    output reg         slowing_indicator_make_q,
    output reg         slowing_indicator_break_q,
    output reg         remote_make_q,
    output reg         remote_break_q,
    output reg         fault_make_q,
    output reg         fault_break_q,
    output reg         caution_make_q,
    output reg         caution_break_q
);
    reg                 rst_s1_q;
    reg                 rst_s2_q;
    wire                rst_q_n;
    wire                start_cl_n;
    wire                halt_cl_n;
    wire                reset_cl_n;
    wire                low_cl_n;
    reg                 start_prev_q;
    reg                 reset_prev_q;
    reg                 halt_hon_prev_q;
    reg  [30:0]         pwrup_cnt_q;
    reg                 ready_q;
    reg  [`PRCI_CFG_W-1:0] cfg_q;
    reg  [7:0]          cnt_start_q;
    reg  [7:0]          cnt_stop_q;
    reg  [7:0]          cnt_reset_q;
    wire                remote_avail;
    wire                halt_honour;
    wire                halt_open_hon;
    wire                start_edge;
    wire                reset_edge;
    wire                stop_edge;
    wire                apb_acc;
    wire                apb_done;
    wire [6:0]          relay_vec;
    reg  [31:0]         rd_d;
    reg                 err_d;
    reg  [1:0]          ap_q;
    reg  [1:0]          ap_d;

    localparam [1:0] AP_IDLE = 2'b01;
    localparam [1:0] AP_ACK  = 2'b10;

    // Eight-bit read-only counters wrap; software takes differences.
    function [7:0] inc8;
        input [7:0] v;
        begin
            inc8 = v + 8'h01;
        end
    endfunction

    function hit;
        input [7:0] addr;
        input [7:0] off;
        begin
            hit = (addr[7:2] == off[7:2]);
        end
    endfunction

    // Reset is asserted at once and released in step with the clock.
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_q_n = rst_s2_q;

    // Contact inputs read high while open and low while shorted to ground.
    prci_debounce #(.CW(21), .DEB_CYC(DEB_CYC), .IDLE_LVL(1'b1)) u_db_start (
        .clock   (clock),
        .rst_n   (rst_q_n),
        .raw     (start_n),
        .clean_q (start_cl_n)
    );
    prci_debounce #(.CW(21), .DEB_CYC(DEB_CYC), .IDLE_LVL(1'b1)) u_db_halt (
        .clock   (clock),
        .rst_n   (rst_q_n),
        .raw     (halt_n),
        .clean_q (halt_cl_n)
    );
    prci_debounce #(.CW(21), .DEB_CYC(DEB_CYC), .IDLE_LVL(1'b1)) u_db_reset (
        .clock   (clock),
        .rst_n   (rst_q_n),
        .raw     (reset_n),
        .clean_q (reset_cl_n)
    );
    prci_debounce #(.CW(21), .DEB_CYC(DEB_CYC), .IDLE_LVL(1'b1)) u_db_low (
        .clock   (clock),
        .rst_n   (rst_q_n),
        .raw     (low_speed_n),
        .clean_q (low_cl_n)
    );

    // Power-up hold-off; nothing remote but halt with the serial setting acts until it has run out.
    always @(posedge clock or negedge rst_q_n)
    begin
        if (!rst_q_n)
        begin
            pwrup_cnt_q <= 31'h0000_0000;
            ready_q     <= 1'b0;
        end
        else if (!ready_q)
        begin
            pwrup_cnt_q <= pwrup_cnt_q + 31'h0000_0001;
            if (pwrup_cnt_q >= PWRUP_CYC - 31'h0000_0001)
                ready_q <= 1'b1;
        end
    end

    assign remote_avail  = ready_q & remote_sel;
    // With the serial setting the halt contact serves as an interlock.
    assign halt_honour   = remote_avail | (serial_mode &
                           cfg_q[`PRCI_CFG_HALT_SER]);
    assign halt_open_hon = halt_honour & halt_cl_n;
    assign start_edge    = start_prev_q & ~start_cl_n;
    assign reset_edge    = reset_prev_q & ~reset_cl_n;
    assign stop_edge     = halt_open_hon & ~halt_hon_prev_q;

    // Commands taken from the contacts.
    always @(posedge clock or negedge rst_q_n)
    begin
        if (!rst_q_n)
        begin
            start_prev_q    <= 1'b1;
            reset_prev_q    <= 1'b1;
            halt_hon_prev_q <= 1'b0;
            start_cmd_q     <= 1'b0;
            stop_cmd_q      <= 1'b0;
            reset_cmd_q     <= 1'b0;
            run_allow_q     <= 1'b0;
            low_speed_q     <= 1'b0;
            cnt_start_q     <= 8'h00;
            cnt_stop_q      <= 8'h00;
            cnt_reset_q     <= 8'h00;
        end
        else
        begin
            start_prev_q    <= start_cl_n;
            reset_prev_q    <= reset_cl_n;
            halt_hon_prev_q <= halt_open_hon;
            // A closed halt line is the run permit of a latching switch.
            run_allow_q     <= ~halt_open_hon;
            start_cmd_q     <= start_edge & remote_avail &
                               ~halt_open_hon;
            stop_cmd_q      <= stop_edge;
            reset_cmd_q     <= reset_edge & remote_avail;
            low_speed_q     <= remote_avail & ~low_cl_n;
            if (start_edge & remote_avail & ~halt_open_hon)
                cnt_start_q <= inc8(cnt_start_q);
            if (stop_edge)
                cnt_stop_q  <= inc8(cnt_stop_q);
            if (reset_edge & remote_avail)
                cnt_reset_q <= inc8(cnt_reset_q);
        end
    end

    // Relay coils stay released until the hold-off ends, so every make
    // contact is open and every break contact closed at power-up.
    always @(posedge clock or negedge rst_q_n)
    begin
        if (!rst_q_n)
        begin
            spin_make_q               <= 1'b0;
            spin_break_q              <= 1'b1;
            rated_make_q              <= 1'b0;
            rated_break_q             <= 1'b1;
            spinup_make_q             <= 1'b0;
            spinup_break_q            <= 1'b1;
            slowing_indicator_make_q  <= 1'b0;
            slowing_indicator_break_q <= 1'b1;
            remote_make_q             <= 1'b0;
            remote_break_q            <= 1'b1;
            fault_make_q              <= 1'b0;
            fault_break_q             <= 1'b1;
            caution_make_q            <= 1'b0;
            caution_break_q           <= 1'b1;
        end
        else
        begin
            spin_make_q               <= relay_vec[0];
            spin_break_q              <= ~relay_vec[0];
            rated_make_q              <= relay_vec[1];
            rated_break_q             <= ~relay_vec[1];
            spinup_make_q             <= relay_vec[2];
            spinup_break_q            <= ~relay_vec[2];
            slowing_indicator_make_q  <= relay_vec[3];
            slowing_indicator_break_q <= ~relay_vec[3];
            remote_make_q             <= relay_vec[4];
            remote_break_q            <= ~relay_vec[4];
            fault_make_q              <= relay_vec[5];
            fault_break_q             <= ~relay_vec[5];
            caution_make_q            <= relay_vec[6];
            caution_break_q           <= ~relay_vec[6];
        end
    end

    assign relay_vec[0] = ready_q & rotating;
    assign relay_vec[1] = ready_q & rated_speed;
    assign relay_vec[2] = ready_q & accelerating;
    assign relay_vec[3] = ready_q & decelerating;
    assign relay_vec[4] = remote_avail &
                          (cfg_q[`PRCI_CFG_REMOTE_ALT] |
                           ~regen_braking);
    // The alternative setting energises on health, so a dead unit reads
    // as failed on the make contact.
    assign relay_vec[5] = ready_q & (alarm ^
                          cfg_q[`PRCI_CFG_ALARM_ALT]);
    assign relay_vec[6] = ready_q & (warning ^
                          cfg_q[`PRCI_CFG_WARN_ALT]);

    // APB slave with one wait state: pready rises in the second access
    // cycle; read data is loaded on the edge that raises it, the write on the next edge.
    assign apb_acc  = psel & penable;
    assign apb_done = apb_acc & pready;

    // Transfer phase: the answer cycle always drops back to idle, so an
    // access that is still held is answered only once per wait state.
    always @*
    begin
        ap_d = AP_IDLE;
        case (ap_q)
            AP_IDLE:
            begin
                if (apb_acc)
                    ap_d = AP_ACK;
            end
            AP_ACK:
            begin
                ap_d = AP_IDLE;
            end
            default:
            begin
                ap_d = AP_IDLE;
            end
        endcase
    end

    always @*
    begin
        rd_d  = 32'h0000_0000;
        err_d = 1'b0;
        if (hit(paddr, `PRCI_OFF_CFG))
            rd_d = {{(32-`PRCI_CFG_W){1'b0}}, cfg_q};
        else if (hit(paddr, `PRCI_OFF_STATUS))
            rd_d = {19'h0_0000, relay_vec, remote_avail, ready_q,
                    ~low_cl_n, ~reset_cl_n, ~halt_cl_n, ~start_cl_n};
        else if (hit(paddr, `PRCI_OFF_EVCNT))
            rd_d = {8'h00, cnt_reset_q, cnt_stop_q, cnt_start_q};
        else
            err_d = 1'b1;
        if (pwrite & (hit(paddr, `PRCI_OFF_STATUS) |
                      hit(paddr, `PRCI_OFF_EVCNT)))
            err_d = 1'b1;
    end

    always @(posedge clock or negedge rst_q_n)
    begin
        if (!rst_q_n)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            cfg_q   <= `PRCI_CFG_RST;
            ap_q    <= AP_IDLE;
        end
        else
        begin
            ap_q    <= ap_d;
            pready  <= ap_d[1];
            pslverr <= ap_d[1] & err_d;
            if (ap_d[1] & ~pwrite)
                prdata <= rd_d;
            else if (!apb_acc)
                prdata <= 32'h0000_0000;
            if (apb_done & pwrite & hit(paddr, `PRCI_OFF_CFG))
                cfg_q <= pwdata[`PRCI_CFG_W-1:0];
        end
    end
endmodule

// >>> tb/prci_chk.sv
// Checker for the pump remote contact interface, bound to the top module.
`timescale 1ns/1ps
module prci_chk #(
    parameter [30:0] PWRUP_CYC = 31'h0000_0064,
    parameter [20:0] DEB_CYC   = 21'h00_0004
) (
    input wire clock,
    input wire rst_n,
    input wire start_n,
    input wire reset_n,
    input wire low_speed_n,
    input wire remote_sel,
    input wire rotating,
    input wire start_cmd_q,
    input wire reset_cmd_q,
    input wire run_allow_q,
    input wire low_speed_q,
    input wire spin_make_q,
    input wire spin_break_q,
    input wire remote_make_q,
    input wire fault_make_q,
    input wire fault_break_q,
    input wire caution_make_q,
    input wire caution_break_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Cycles since reset and how long the start, reset and reduced-speed contacts have been held shorted.
    reg [31:0] up_q, sl_q, rl_q, ll_q;
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {up_q, sl_q, rl_q, ll_q} <= 128'h0;
        end
        else
        begin
            up_q <= up_q + {31'h0, up_q != 32'hffff_ffff};
            sl_q <= start_n ? 32'h0 : sl_q + 32'h1;
            rl_q <= reset_n ? 32'h0 : rl_q + 32'h1;
            ll_q <= low_speed_n ? 32'h0 : ll_q + 32'h1;
        end
    end
    sequence s_one_start;
        start_cmd_q ##1 !start_cmd_q;
    endsequence
    sequence s_one_reset;
        reset_cmd_q ##1 !reset_cmd_q;
    endsequence
    AST_START_PULSE: assert property (
        $rose(start_cmd_q) |-> s_one_start)
        else $error("start request longer than one cycle");
    AST_RESET_ONE: assert property (
        $rose(reset_cmd_q) |-> s_one_reset)
        else $error("reset request longer than one cycle");
    AST_START_DEB: assert property (
        start_cmd_q |-> sl_q >= DEB_CYC)
        else $error("start accepted before the contact settled");
    AST_RESET_DEB: assert property (
        reset_cmd_q |-> rl_q >= DEB_CYC)
        else $error("reset accepted before the contact settled");
    AST_LOW_DEB: assert property (
        $rose(low_speed_q) |-> ll_q >= DEB_CYC)
        else $error("reduced speed taken before the contact settled");
    AST_PWRUP: assert property (
        (spin_make_q | remote_make_q | fault_make_q
        | caution_make_q) |-> up_q >= PWRUP_CYC)
        else $error("status relay closed during power-up hold-off");
    AST_SPIN: assert property (spin_break_q != spin_make_q
        && (!spin_make_q || $past(rotating)))
        else $error("spinning relay pair wrong");
    AST_REMOTE: assert property (remote_make_q |->
        $past(remote_sel) || $past(remote_sel, 2))
        else $error("remote relay closed without remote selection");
    AST_PAIRS: assert property (
        fault_break_q != fault_make_q
        && caution_break_q != caution_make_q)
        else $error("fault or caution pair not complementary");
    AST_START_GATE: assert property (start_cmd_q |->
        run_allow_q && $past(remote_sel))
        else $error("start issued while halted or local");
endmodule
bind prci_top prci_chk #(.PWRUP_CYC(PWRUP_CYC), .DEB_CYC(DEB_CYC)) u_chk (
    .clock(clock), .rst_n(rst_n), .start_n(start_n), .reset_n(reset_n),
    .low_speed_n(low_speed_n), .remote_sel(remote_sel), .rotating(rotating),
    .start_cmd_q(start_cmd_q), .reset_cmd_q(reset_cmd_q),
    .run_allow_q(run_allow_q), .low_speed_q(low_speed_q),
    .spin_make_q(spin_make_q), .spin_break_q(spin_break_q),
    .remote_make_q(remote_make_q), .fault_make_q(fault_make_q),
    .fault_break_q(fault_break_q), .caution_make_q(caution_make_q),
    .caution_break_q(caution_break_q));

// >>> tb/prci_host_model.sv
// Host controller model: latching dry contacts with optional chatter.
`timescale 1ns/1ps
module prci_host_model #(
    parameter int CHATTER = 6
) (
    input  wire       clock,
    input  wire [3:0] want,
    input  wire       bounce,
    output wire       start_n,
    output wire       halt_n,
    output wire       reset_n,
    output wire       low_speed_n
);
    // Index 0 start, 1 halt, 2 reset, 3 reduced speed; want 1 = closed.
    logic [3:0] prev_q = 4'h0;
    logic [3:0] pin_q  = 4'hf;
    int         cnt_q [4];
    always @(posedge clock)
    begin
        for (int i = 0; i < 4; i++)
        begin
            // Chatter starts only on a change of want while bounce is set.
            if (want[i] != prev_q[i] && bounce)
                cnt_q[i] <= CHATTER;
            else if (cnt_q[i] > 0)
                cnt_q[i] <= cnt_q[i] - 1;
            pin_q[i] <= (cnt_q[i] > 0) ? ~pin_q[i] : ~want[i];
        end
        prev_q <= want;
    end
    assign {low_speed_n, reset_n, halt_n, start_n} = pin_q;
endmodule

// >>> tb/prci_top_tb.sv
// Self-checking bench for the pump remote contact interface.
`timescale 1ns/1ps
module prci_top_tb;
    localparam [30:0] PWR = 31'h0000_0064;
    localparam [20:0] DEB = 21'h00_0004;
    logic        clock, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0]  sq, mk, bk;
    logic [3:0]  w, cfg;
    logic        rsel, smode, bnc, err, sn, hn, rn, ln, st, sp, rs, ra, lo;
    int          errors = 0, n_compared = 0, cyc = 0;
    int          n_st = 0, n_sp = 0, n_rs = 0, b0, b1;
    prci_host_model u_host (.clock(clock), .want(w), .bounce(bnc),
        .start_n(sn), .halt_n(hn), .reset_n(rn), .low_speed_n(ln));
    prci_top #(.PWRUP_CYC(PWR), .DEB_CYC(DEB)) dut (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .start_n(sn), .halt_n(hn),
        .reset_n(rn), .low_speed_n(ln), .remote_sel(rsel),
        .serial_mode(smode), .rotating(sq[0]), .rated_speed(sq[1]),
        .accelerating(sq[2]), .decelerating(sq[3]), .regen_braking(sq[4]),
        .alarm(sq[5]), .warning(sq[6]), .start_cmd_q(st), .stop_cmd_q(sp),
        .reset_cmd_q(rs), .run_allow_q(ra), .low_speed_q(lo),
        .spin_make_q(mk[0]), .spin_break_q(bk[0]), .rated_make_q(mk[1]),
        .rated_break_q(bk[1]), .spinup_make_q(mk[2]), .spinup_break_q(bk[2]),
        .slowing_indicator_make_q(mk[3]), .slowing_indicator_break_q(bk[3]),
        .remote_make_q(mk[4]), .remote_break_q(bk[4]), .fault_make_q(mk[5]),
        .fault_break_q(bk[5]), .caution_make_q(mk[6]),
        .caution_break_q(bk[6]));
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cyc++;
        n_st += (st === 1'b1);
        n_sp += (sp === 1'b1);
        n_rs += (rs === 1'b1);
        if (cyc == 20000)
        begin
            errors++;
            results();
        end
    end
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Entered just after a rising edge; leaves one idle cycle behind.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    function automatic logic [6:0] exp_relays(input logic [3:0] c,
                                              input logic [6:0] s,
                                              input logic r);
        exp_relays = {s[6] ^ c[3], s[5] ^ c[0], r & (c[1] | ~s[4]), s[3:0]};
    endfunction
    task automatic chk_relays;
        logic [6:0] e;
        e = exp_relays(cfg, sq, rsel);
        chk32({25'h0, mk}, {25'h0, e});
        chk32({25'h0, bk}, {25'h0, ~e});
        apb(1'b0, 8'h04, 32'h0);
        chk32(rd, {19'h0, e, rsel, 1'b1, w});
    endtask
    task automatic rand_relays(input int n);
        for (int k = 0; k < n; k++)
        begin
            sq <= (k == 0) ? 7'h1f : 7'($urandom);
            repeat (3) @(posedge clock);
            chk_relays();
        end
    endtask
    task automatic set_w(input int k, input logic v);
        w[k] <= v;
        repeat (40) @(posedge clock);
    endtask
    initial
    begin
        {rst_n, psel, penable, pwrite, bnc, smode, paddr, pwdata} = 46'h0;
        {sq, w, cfg, rsel} = 16'h0001;
        void'($urandom(32'h9b1c_2e79));
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        sq <= 7'h0f;
        repeat (50) @(posedge clock);
        chk32({18'h0, mk, bk}, 32'h7f);
        repeat (PWR) @(posedge clock);
        rand_relays(12);
        $display("test relays done");
        bnc <= 1'b1;
        set_w(1, 1'b1);
        chk32({31'h0, ra}, 32'h1);
        b0 = n_st;
        set_w(0, 1'b1);
        chk32(n_st - b0, 32'h1);
        set_w(0, 1'b0);
        b0 = n_rs;
        set_w(2, 1'b1);
        repeat (40) @(posedge clock);
        chk32(n_rs - b0, 32'h1);
        set_w(2, 1'b0);
        set_w(2, 1'b1);
        chk32(n_rs - b0, 32'h2);
        set_w(2, 1'b0);
        set_w(3, 1'b1);
        chk32({31'h0, lo}, 32'h1);
        set_w(3, 1'b0);
        chk32({31'h0, lo}, 32'h0);
        $display("test contacts done");
        b0 = n_sp;
        b1 = n_st;
        set_w(1, 1'b0);
        set_w(0, 1'b1);
        chk32(n_sp - b0, 32'h1);
        chk32({31'h0, ra}, 32'h0);
        chk32(n_st - b1, 32'h0);
        set_w(0, 1'b0);
        $display("test halt done");
        rsel <= 1'b0;
        smode <= 1'b1;
        b0 = n_st;
        b1 = n_rs;
        set_w(0, 1'b1);
        set_w(2, 1'b1);
        chk32(n_st - b0, 32'h0);
        chk32(n_rs - b1, 32'h0);
        chk32({31'h0, ra}, 32'h1);
        chk_relays();
        apb(1'b1, 8'h00, 32'h4);
        cfg = 4'h4;
        repeat (40) @(posedge clock);
        chk32({31'h0, ra}, 32'h0);
        set_w(0, 1'b0);
        set_w(2, 1'b0);
        $display("test local done");
        rsel <= 1'b1;
        smode <= 1'b0;
        apb(1'b1, 8'h00, 32'hb);
        cfg = 4'hb;
        apb(1'b0, 8'h00, 32'h0);
        chk32(rd, 32'hb);
        rand_relays(8);
        apb(1'b0, 8'h0c, 32'h0);
        chk32({31'h0, err}, 32'h1);
        chk32(rd, 32'h0);
        apb(1'b1, 8'h04, 32'hffff_ffff);
        chk32({31'h0, err}, 32'h1);
        apb(1'b0, 8'h08, 32'h0);
        chk32(rd, {8'h0, n_rs[7:0], n_sp[7:0], n_st[7:0]});
        $display("test config done");
        results();
    end
endmodule
